// *** clock_gear_timing_warmup.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "clock_gear_defs.svh"
module clock_gear_timing_warmup
  import clock_gear_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        osc_clock,
  input  wire logic        ext_high_clock,
  input  wire logic        low_freq_clock,
  input  wire logic        stop_release,
  output logic             main_sys_tick,
  output logic             gear_tick,
  output logic      [2:0]  prescaler_out,
  output logic      [20:0] divider_out,
  output logic             cpu_reset_n,
  output logic             sys_clock_reset,
  output logic             stop_done
);

  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_in;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_c;
  logic [3:0] rise;
  assign pin_in = {stop_release, low_freq_clock, ext_high_clock, osc_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rstn) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
        end else if (ce) begin
          sync_a[gi] <= pin_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
      assign rise[gi] = sync_b[gi] & ~sync_c[gi];
    end
  endgenerate

  logic osc_tick;
  logic ext_tick;
  logic low_tick;
  logic release_evt;
  assign osc_tick    = rise[0];
  assign ext_tick    = rise[1];
  assign low_tick    = rise[2];
  assign release_evt = rise[3];

  // ==========================================================
  // registers
  logic [1:0]  gear_sel;
  logic        divider_stage_nine_source;
  logic        oscsel;
  logic        hosc_en;
  logic        xen;
  logic        xten;
  logic        main_clock_source_select;
  logic [1:0]  wu_sel;
  logic [1:0]  wu_div;
  logic [7:0]  wu_cmp;
  logic        wr_ok;
  logic        stop_req;
  logic        soft_req;
  wu_state_t   state;
  logic [13:0] wu_cnt;
  logic [31:0] cycles;
  logic        main_src;
  logic        switching;
  logic        wu_done;

  assign wr_ok = write & !waitrequest;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gear_sel <= `RST_GEAR;
      divider_stage_nine_source <= 1'b0;
      oscsel   <= 1'b0;
      hosc_en  <= `RST_HOSC_EN;
      xen      <= 1'b0;
      xten     <= 1'b0;
      main_clock_source_select <= 1'b0;
      wu_sel   <= `RST_WU_SEL;
      wu_div   <= `RST_WU_DIV;
      wu_cmp   <= `RST_WU_CMP;
      stop_req <= 1'b0;
      soft_req <= 1'b0;
    end else if (ce) begin
      stop_req <= 1'b0;
      soft_req <= 1'b0;
      if (wr_ok) begin
        if (hit(address, `OFS_GEAR)) begin
          gear_sel <= writedata[1:0];
        end else if (hit(address, `OFS_SYS_ONE)) begin
          divider_stage_nine_source <= writedata[`BIT_STAGE_NINE_SRC];
          oscsel   <= main_clock_source_select ? oscsel
                                               : writedata[`BIT_OSCSEL];
          stop_req <= writedata[`BIT_STOP];
        end else if (hit(address, `OFS_SYS_TWO)) begin
          hosc_en <= writedata[`BIT_HOSC_EN];
          xen     <= writedata[`BIT_XEN];
          xten    <= writedata[`BIT_XTEN];
          main_clock_source_select <= writedata[`BIT_MAIN_SRC_SEL];
        end else if (hit(address, `OFS_WU_CTRL)) begin
          wu_sel   <= writedata[1:0];
          wu_div   <= writedata[3:2];
          soft_req <= writedata[`BIT_WU_START];
        end else if (hit(address, `OFS_WU_CMP)) begin
          wu_cmp <= writedata[7:0];
        end
      end
    end
  end

  // ==========================================================
  // avalon slave answer, one wait cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else if (ce) begin
      waitrequest <= !((read | write) & waitrequest);
      if (read & waitrequest) begin
        if (hit(address, `OFS_GEAR)) begin
          readdata <= {30'h0, gear_sel};
        end else if (hit(address, `OFS_SYS_ONE)) begin
          readdata <= {27'h0, divider_stage_nine_source, oscsel, 3'h0};
        end else if (hit(address, `OFS_SYS_TWO)) begin
          readdata <= {24'h0, hosc_en, xen, xten, main_clock_source_select,
                       4'h0};
        end else if (hit(address, `OFS_WU_CTRL)) begin
          readdata <= {28'h0, wu_div, wu_sel};
        end else if (hit(address, `OFS_WU_CMP)) begin
          readdata <= {24'h0, wu_cmp};
        end else if (hit(address, `OFS_STATUS)) begin
          readdata <= {11'h0, state, cpu_reset_n, switching,
                       main_src, 1'b0, wu_cnt};
        end else if (hit(address, `OFS_CYCLES)) begin
          readdata <= cycles;
        end else begin
          readdata <= 32'h0;
        end
      end
    end
  end

  // ==========================================================
  // clock gear
  logic       high_tick;
  logic [1:0] gear_cnt;
  logic [1:0] gear_act;
  logic [1:0] gear_top;
  logic [1:0] gear_wait;
  logic       gear_pend;
  logic       run_clk;
  logic       gear_end;

  assign high_tick = oscsel ? ext_tick : osc_tick;
  assign run_clk   = (state == ST_RUN) || (state == ST_SOFT_WARM);
  always_comb begin
    case (gear_act)
      2'h0:    gear_top = 2'h3;
      2'h1:    gear_top = 2'h1;
      default: gear_top = 2'h0;
    endcase
  end
  assign gear_end = high_tick && (gear_cnt >= gear_top);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gear_cnt  <= 2'h0;
      gear_act  <= `RST_GEAR;
      gear_wait <= 2'h0;
      gear_pend <= 1'b0;
      gear_tick <= 1'b0;
    end else if (ce) begin
      gear_tick <= gear_end;
      if (high_tick) begin
        gear_cnt <= gear_end ? 2'h0 : gear_cnt + 2'h1;
      end
      if (wr_ok && hit(address, `OFS_GEAR) && writedata[1:0] != 2'h3) begin
        gear_wait <= 2'h2;
        gear_pend <= 1'b0;
      end else if (gear_wait != 2'h0 && main_sys_tick && !main_src) begin
        gear_wait <= gear_wait - 2'h1;
        gear_pend <= (gear_wait == 2'h1);
      end
      if (gear_pend && gear_end) begin
        gear_act  <= gear_sel;
        gear_pend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // main system clock select
  logic [1:0] low_q;
  logic       low4_tick;
  assign low4_tick = low_tick && (low_q == `LOW_QUARTER);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_q <= 2'h0;
    end else if (ce && low_tick) begin
      low_q <= low_q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      main_src        <= 1'b0;
      switching       <= 1'b0;
      main_sys_tick   <= 1'b0;
      sys_clock_reset <= 1'b0;
      cycles          <= 32'h0;
    end else if (ce) begin
      switching       <= (main_clock_source_select != main_src);
      sys_clock_reset <= 1'b0;
      if (main_clock_source_select != main_src) begin
        if (main_clock_source_select ? low4_tick : gear_end) begin
          main_src <= main_clock_source_select;
        end
        if (main_src ? !xten : !(oscsel ? xen : hosc_en)) begin
          sys_clock_reset <= 1'b1;
        end
      end
      main_sys_tick <= run_clk && (main_src ? low4_tick : gear_end);
      if (main_sys_tick) begin
        cycles <= cycles + 32'h1;
      end
    end
  end

  // ==========================================================
  // prescaler and 21-stage divider
  logic        pre_carry;
  logic        st8_carry;
  logic        st9_in;
  logic        div_clr;
  assign pre_carry = gear_end && !main_src && prescaler_out == 3'h7;
  assign st8_carry = pre_carry && divider_out[7:0] == 8'hff;
  assign st9_in    = (divider_stage_nine_source ||
                      main_clock_source_select) ? low4_tick : st8_carry;
  assign div_clr   = (state == ST_WARM_STOP) && wu_done;

  always_ff @(posedge clk) begin
    if (!rstn || sys_clock_reset) begin
      prescaler_out <= 3'h0;
      divider_out   <= 21'h0;
    end else if (ce) begin
      if (div_clr) begin
        prescaler_out <= 3'h0;
        divider_out   <= 21'h0;
      end else begin
        if (gear_end && !main_src) begin
          prescaler_out <= prescaler_out + 3'h1;
        end
        if (pre_carry) begin
          divider_out[7:0] <= divider_out[7:0] + 8'h1;
        end
        if (st9_in) begin
          divider_out[20:8] <= divider_out[20:8] + 13'h1;
        end
      end
    end
  end

  // ==========================================================
  // warm-up counter
  wu_src_t     stop_src;
  wu_src_t     cur_src;
  logic        src_tick;
  logic [2:0]  half_chain;
  logic [2:0]  div_mask;
  logic        cnt_tick;
  logic        counting;

  assign cur_src = (state == ST_WARM_STOP) ? stop_src
                                           : wu_src_t'(wu_sel);
  always_comb begin
    case (cur_src)
      SRC_OSC: src_tick = osc_tick;
      SRC_EXT: src_tick = ext_tick;
      SRC_LOW: src_tick = low_tick;
      default: src_tick = 1'b0;
    endcase
    case (wu_div)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  assign counting = (state == ST_WARM_POR) || (state == ST_SOFT_WARM) ||
                    (state == ST_WARM_STOP);
  assign cnt_tick = counting && src_tick &&
                    ((half_chain & div_mask) == div_mask);
  assign wu_done  = counting && (wu_cnt[13:6] == wu_cmp);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      half_chain <= 3'h0;
      wu_cnt     <= 14'h0;
    end else if (ce) begin
      if (wu_done) begin
        half_chain <= 3'h0;
        wu_cnt     <= 14'h0;
      end else if (counting && src_tick) begin
        half_chain <= half_chain + 3'h1;
        if (cnt_tick) begin
          wu_cnt <= wu_cnt + 14'h1;
        end
      end else if (state == ST_RUN && stop_req) begin
        wu_cnt <= 14'h0;
      end
    end
  end

  // ==========================================================
  // warm-up sequencing and stop
  always_ff @(posedge clk) begin
    if (!rstn || sys_clock_reset) begin
      state       <= ST_WARM_POR;
      stop_src    <= SRC_OSC;
      cpu_reset_n <= 1'b0;
      stop_done   <= 1'b0;
    end else if (ce) begin
      stop_done <= 1'b0;
      case (state)
        ST_WARM_POR: begin
          if (wu_done) begin
            state       <= ST_RUN;
            cpu_reset_n <= 1'b1;
          end
        end
        ST_RUN: begin
          if (stop_req) begin
            state    <= ST_STOP;
            stop_src <= main_src ? SRC_LOW : (oscsel ? SRC_EXT : SRC_OSC);
          end else if (soft_req) begin
            state <= ST_SOFT_WARM;
          end
        end
        ST_SOFT_WARM: begin
          if (stop_req) begin
            state    <= ST_STOP;
            stop_src <= main_src ? SRC_LOW : (oscsel ? SRC_EXT : SRC_OSC);
          end else if (wu_done) begin
            state <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (release_evt) begin
            state <= ST_WARM_STOP;
          end
        end
        ST_WARM_STOP: begin
          if (wu_done) begin
            state     <= ST_RUN;
            stop_done <= 1'b1;
          end
        end
        default: begin
          state <= ST_WARM_POR;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** clock_gear_defs.svh ***
`ifndef CLOCK_GEAR_DEFS_SVH
`define CLOCK_GEAR_DEFS_SVH
`define OFS_GEAR      8'h00
`define OFS_SYS_ONE   8'h04
`define OFS_SYS_TWO   8'h08
`define OFS_WU_CTRL   8'h0c
`define OFS_WU_CMP    8'h10
`define OFS_STATUS    8'h14
`define OFS_CYCLES    8'h18
`define BIT_STOP      7
`define BIT_STAGE_NINE_SRC 4
`define BIT_OSCSEL    3
`define BIT_HOSC_EN   7
`define BIT_XEN       6
`define BIT_XTEN      5
`define BIT_MAIN_SRC_SEL 4
`define BIT_WU_START  4
`define RST_GEAR      2'h0
`define RST_WU_SEL    2'h0
`define RST_WU_DIV    2'h3
`define RST_WU_CMP    8'h66
`define RST_HOSC_EN   1'b1
`define LOW_QUARTER   2'h3
`endif

// *** clock_gear_pkg.sv ***
package clock_gear_pkg;
  typedef enum logic [2:0] {
    ST_WARM_POR  = 3'b000,
    ST_RUN       = 3'b001,
    ST_SOFT_WARM = 3'b010,
    ST_STOP      = 3'b011,
    ST_WARM_STOP = 3'b100
  } wu_state_t;
  typedef enum logic [1:0] {
    SRC_OSC = 2'b00,
    SRC_EXT = 2'b01,
    SRC_LOW = 2'b10
  } wu_src_t;
endpackage

// *** clock_gear_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "clock_gear_defs.svh"
// ==========
// checker on the top ports
module clock_gear_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        osc_clock,
  input wire logic        ext_high_clock,
  input wire logic        low_freq_clock,
  input wire logic        stop_release,
  input wire logic        main_sys_tick,
  input wire logic        gear_tick,
  input wire logic [2:0]  prescaler_out,
  input wire logic [20:0] divider_out,
  input wire logic        cpu_reset_n,
  input wire logic        sys_clock_reset,
  input wire logic        stop_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========
  // bus answer
  property p_answer;
    ce && (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_one;
    ce && !waitrequest |=> waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_unmapped;
    ce && read && waitrequest && (address == 8'h1c || address >= 8'h20)
      |=> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped nonzero");
  // ==========
  // ticks, resets, warm-up
  property p_gear_gap;
    gear_tick |=> !gear_tick [*2];
  endproperty
  a_gear_gap: assert property (p_gear_gap) else $error("gear short");
  property p_main_gap;
    main_sys_tick |=> !main_sys_tick [*2];
  endproperty
  a_main_gap: assert property (p_main_gap) else $error("cycle short");
  property p_fault;
    sys_clock_reset |-> ##[0:3] !cpu_reset_n;
  endproperty
  a_fault: assert property (p_fault) else $error("fault no reset");
  property p_por;
    $rose(rstn) |-> prescaler_out == 3'h0 && divider_out == 21'h0
      && !cpu_reset_n ##1 !cpu_reset_n [*7];
  endproperty
  a_por: assert property (p_por) else $error("reset state bad");
  property p_hold;
    $fell(cpu_reset_n) |-> sys_clock_reset || $past(sys_clock_reset)
      || $past(sys_clock_reset, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("core reset dropped");
  property p_stop_clr;
    stop_done |-> ##[0:1] (prescaler_out == 3'h0 && divider_out == 21'h0);
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("no clear");
  property p_stop_pulse;
    stop_done |=> !stop_done;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) else $error("done long");
endmodule
`default_nettype wire

// *** tb_clock_gear_timing_warmup.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "clock_gear_defs.svh"
bind clock_gear_timing_warmup clock_gear_sva clock_gear_sva_inst (.clk, .rstn,
  .ce, .address, .read, .write, .writedata, .readdata, .waitrequest,
  .osc_clock, .ext_high_clock, .low_freq_clock, .stop_release, .main_sys_tick,
  .gear_tick, .prescaler_out, .divider_out, .cpu_reset_n, .sys_clock_reset,
  .stop_done);
// ==========
// bench
module tb_clock_gear_timing_warmup import clock_gear_pkg::*;;
  logic        clk, rstn, ce, read, write, osc_clock, low_freq_clock;
  logic        ext_high_clock, stop_release, waitrequest, main_sys_tick;
  logic        gear_tick, cpu_reset_n, sys_clock_reset, stop_done;
  logic [7:0]  address, cp;
  logic [31:0] writedata, readdata, rd;
  logic [2:0]  prescaler_out, pq;
  logic [20:0] divider_out, d0;
  logic [1:0]  c, dv;
  int          n_mismatch, total_checks, edges, sp, e, n;
  clock_gear_timing_warmup clock_gear_timing_warmup_inst (.clk, .rstn, .ce,
    .address, .read, .write, .writedata, .readdata, .waitrequest, .osc_clock,
    .ext_high_clock, .low_freq_clock, .stop_release, .main_sys_tick,
    .gear_tick, .prescaler_out, .divider_out, .cpu_reset_n, .sys_clock_reset,
    .stop_done);
  always #20 clk = ~clk;
  always #160 osc_clock = ~osc_clock;
  always #240 low_freq_clock = ~low_freq_clock;
  always @(posedge osc_clock) edges++;
  // ==========
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo(input bit bad, input string nm);
    if (bad) begin
      check(nm, 32'h0, 32'h1);
      final_report();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    tmo(waitrequest !== 1'b0, "bus");
  endtask
  function automatic logic pick(input int s);
    logic [4:0] v;
    v = {sys_clock_reset, stop_done, cpu_reset_n, main_sys_tick, gear_tick};
    return v[s];
  endfunction
  task automatic wait_hi(input int s, lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pick(s) !== 1'b1 && k < lim);
    tmo(k >= lim, "wait");
  endtask
  function automatic int gear_gap(input logic [1:0] g, input int prev);
    return (g == 2'h3) ? prev : 8 * (4 >> g);
  endfunction
  function automatic logic in_win(input int k, base);
    return k >= base && k <= base + 3;
  endfunction
  // ==========
  // sequence
  initial begin
    {clk, rstn, read, write, osc_clock, low_freq_clock} = '0;
    {ext_high_clock, stop_release, address, writedata} = '0;
    ce = 1'b1;
    void'($urandom(21756));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    edges = 0;
    bus(1'b0, `OFS_GEAR, 32'h0);
    check("gear_rst", rd, 32'h0);
    bus(1'b0, `OFS_WU_CTRL, 32'h0);
    check("wu_ctrl_rst", rd & 32'hf, 32'hc);
    bus(1'b0, `OFS_WU_CMP, 32'h0);
    check("cmp_rst", rd, 32'h66);
    bus(1'b0, 8'h1c, 32'h0);
    check("unmapped", rd, 32'h0);
    check("core_held", cpu_reset_n, 1'b0);
    bus(1'b1, `OFS_WU_CMP, 32'h1);
    wait_hi(2, 8000, n);
    check("por_len", in_win(edges, 512), 1'b1);
    // gear only changed on the gear clock
    for (int i = 0; i < 6; i++) begin
      c = (i < 4) ? 2'(i) : 2'($urandom_range(2));
      e = gear_gap(c, 32);
      bus(1'b1, `OFS_GEAR, {30'h0, c});
      bus(1'b0, `OFS_GEAR, 32'h0);
      check("gear_rb", rd, {30'h0, c});
      if (c != 2'h3) sp = e;
      repeat (5) wait_hi(0, 400, n);
      check("gear_gap", n, sp);
      repeat (3) wait_hi(1, 400, n);
      check("cycle_gap", n, sp);
    end
    // division and compare set before stop
    for (int j = 0; j < 2; j++) begin
      dv = j ? 2'($urandom_range(3, 1)) : 2'h0;
      cp = 8'($urandom_range(2, 1));
      bus(1'b1, `OFS_WU_CTRL, {28'h0, dv, 2'h2});
      bus(1'b1, `OFS_WU_CMP, {24'h0, cp});
      bus(1'b1, `OFS_SYS_ONE, 32'h80);
      repeat (20) @(posedge clk);
      stop_release <= 1'b1;
      edges = 0;
      wait_hi(3, 10000, n);
      check("stop_len", in_win(edges, (cp * 64) << dv), 1'b1);
      check("stop_clr", {prescaler_out, divider_out}, 24'h0);
      stop_release <= 1'b0;
    end
    bus(1'b1, `OFS_SYS_TWO, 32'ha0);
    bus(1'b1, `OFS_SYS_TWO, 32'hb0);
    repeat (4) wait_hi(1, 400, n);
    check("low_cycle", n, 48);
    {pq, d0} = {prescaler_out, divider_out};
    repeat (200) @(posedge clk);
    check("low_hold", {prescaler_out, divider_out[7:0]}, {pq, d0[7:0]});
    check("st9_runs", divider_out[20:8] != d0[20:8], 1'b1);
    bus(1'b1, `OFS_SYS_TWO, 32'ha0);
    repeat (100) @(posedge clk);
    bus(1'b1, `OFS_SYS_TWO, 32'h30);
    wait_hi(4, 200, n);
    repeat (4) @(posedge clk);
    check("fault_rst", cpu_reset_n, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
